// file: rtl/ext_ctrl_defines.vh
`ifndef EXT_CTRL_DEFINES_VH
`define EXT_CTRL_DEFINES_VH

// apb register byte offsets
`define ECP_ADDR_W 8
`define ECP_OFS_CTRL 8'h00
`define ECP_OFS_OUTCMD 8'h04
`define ECP_OFS_STATUS 8'h08
`define ECP_OFS_INT_STS 8'h0C
`define ECP_OFS_INT_MASK 8'h10
`define ECP_OFS_SEQ_CFG 8'h14
`define ECP_OFS_SEQ_STEP 8'h18

// control register fields
`define ECP_CTRL_EXT_EN 0
`define ECP_CTRL_LINE_SEL 1
`define ECP_CTRL_FW_BUSY 2
`define ECP_CTRL_SYNC0 3
`define ECP_CTRL_SYNC1 4
`define ECP_CTRL_W 5
`define ECP_CTRL_RST 5'h02

// output command register fields (write one to act)
`define ECP_OUTCMD_ON 0
`define ECP_OUTCMD_OFF 1

// command input index, also interrupt status bit
`define ECP_CMD_N 7
`define ECP_CMD_OFF 0
`define ECP_CMD_ON 1
`define ECP_CMD_START 2
`define ECP_CMD_STOP 3
`define ECP_CMD_HOLD 4
`define ECP_CMD_BR0 5
`define ECP_CMD_BR1 6
`define ECP_INT_LIMIT 7
`define ECP_INT_W 8
`define ECP_INT_MASK_RST 8'h00

// sequence configuration fields
`define ECP_SEQ_W 8
`define ECP_SEQ_CFG_RST 24'h000000

`endif

// file: rtl/fall_edge_bank.v
`timescale 1ns/1ps
`default_nettype none

module fall_edge_bank #(
    parameter WIDTH = 7
) (
    // clock and reset
    input wire clock,
    input wire srst,
    input wire ce,
    // qualification
    input wire arm,
    // sampled lines, idle high
    input wire [WIDTH-1:0] level,
    // one-cycle falling edge pulses
    output wire [WIDTH-1:0] fall
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // one history flop per line keeps a single driver per register
            reg prev_r;
            // history tracks even while disarmed, so enabling never fakes an edge
            always @(posedge clock) begin
                if (srst) begin
                    prev_r <= 1'b1;
                end else if (ce) begin
                    prev_r <= level[i];
                end
            end
            assign fall[i] = ce & arm & prev_r & ~level[i];
        end
    endgenerate

endmodule // fall_edge_bank

`default_nettype wire

// file: rtl/external_control_io_port.v
`timescale 1ns/1ps
`default_nettype none
`include "ext_ctrl_defines.vh"

// Operation
// - eight-bit parallel port: command inputs and status outputs
// - without external enable, commands ignored and status outputs held low
// - power-state line high while unit powered and running, else low
// - limiter line high while any of the four limiters operates
// - commands act only on high-to-low transitions; controller supplies falling edges
// - two branch triggers, each branches on its falling edge while a sequence runs; branch 0 wins if both fall together
// - two sequence sync outputs follow the control register sync bits while a sequence runs or holds
// - line sync selected: follow mains line, disregard external sync input
module external_control_io_port (
    // clock, reset, enable
    input wire clock,
    input wire srst,
    input wire ce,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    output wire irq,
    // connector command inputs, active low
    input wire output_off_n,
    input wire output_on_n,
    input wire seq_start_n,
    input wire seq_stop_n,
    input wire seq_hold_n,
    input wire seq_branch0_n,
    input wire seq_branch1_n,
    input wire spare_in,
    // connector status outputs
    output reg power_state,
    output reg output_state,
    output reg limiter_active,
    output reg software_busy,
    output reg seq_sync0,
    output reg seq_sync1,
    output wire spare_out0,
    output wire spare_out1,
    // unit state
    input wire unit_running,
    input wire limit_peak_pos,
    input wire limit_peak_neg,
    input wire limit_avg_current,
    input wire limit_power,
    // sync sources
    input wire line_sync,
    input wire external_sync_input,
    output reg sync_tick,
    // output stage control
    output wire output_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // functions

    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    localparam [2:0] SEQ_IDLE = 3'h1;
    localparam [2:0] SEQ_RUN = 3'h2;
    localparam [2:0] SEQ_HOLD = 3'h4;

    reg [`ECP_CTRL_W-1:0] ctrl_r;
    reg [`ECP_INT_W-1:0] int_sts_r;
    reg [`ECP_INT_W-1:0] int_sts_nxt;
    reg [`ECP_INT_W-1:0] int_mask_r;
    reg [23:0] seq_cfg_r;
    reg [2:0] seq_state_r;
    reg [2:0] seq_state_nxt;
    reg [`ECP_SEQ_W-1:0] step_r;
    reg [`ECP_SEQ_W-1:0] step_nxt;
    reg out_on_r;
    reg out_on_nxt;
    reg limit_prev_r;
    reg sync_prev_r;
    reg [31:0] rd_val;
    reg rd_ok;

    wire ext_en;
    wire line_sel;
    wire wr_en;
    wire setup;
    wire [`ECP_CMD_N-1:0] cmd_level;
    wire [`ECP_CMD_N-1:0] cmd_fall;
    wire limit_any;
    wire sync_sel;
    wire sync_rise;
    wire sw_on;
    wire sw_off;
    wire [`ECP_SEQ_W-1:0] br0_target;
    wire [`ECP_SEQ_W-1:0] br1_target;
    wire [`ECP_SEQ_W-1:0] last_step;

    ////////////////////////////////////////////////////////////////////////////
    // apb handshake

    // zero wait states; a frozen clock enable stretches the access
    assign pready = ce;
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & ce;

    assign ext_en = ctrl_r[`ECP_CTRL_EXT_EN];
    assign line_sel = ctrl_r[`ECP_CTRL_LINE_SEL];
    assign br0_target = seq_cfg_r[7:0];
    assign br1_target = seq_cfg_r[15:8];
    assign last_step = seq_cfg_r[23:16];

    assign sw_on = wr_en & hit(paddr, `ECP_OFS_OUTCMD) & pwdata[`ECP_OUTCMD_ON];
    assign sw_off = wr_en & hit(paddr, `ECP_OFS_OUTCMD) & pwdata[`ECP_OUTCMD_OFF];

    ////////////////////////////////////////////////////////////////////////////
    // command edge detection

    assign cmd_level[`ECP_CMD_OFF] = output_off_n;
    assign cmd_level[`ECP_CMD_ON] = output_on_n;
    assign cmd_level[`ECP_CMD_START] = seq_start_n;
    assign cmd_level[`ECP_CMD_STOP] = seq_stop_n;
    assign cmd_level[`ECP_CMD_HOLD] = seq_hold_n;
    assign cmd_level[`ECP_CMD_BR0] = seq_branch0_n;
    assign cmd_level[`ECP_CMD_BR1] = seq_branch1_n;

    fall_edge_bank #(
        .WIDTH(`ECP_CMD_N)
    ) u_edges (
        .clock(clock),
        .srst(srst),
        .ce(ce),
        .arm(ext_en),
        .level(cmd_level),
        .fall(cmd_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sync source and limiter

    // line sync wins outright; the external input is not even looked at
    assign sync_sel = line_sel ? line_sync : external_sync_input;
    assign sync_rise = ce & sync_sel & ~sync_prev_r;
    assign limit_any = limit_peak_pos | limit_peak_neg | limit_avg_current | limit_power;

    always @(posedge clock) begin
        if (srst) begin
            sync_prev_r <= 1'b0;
            limit_prev_r <= 1'b0;
            sync_tick <= 1'b0;
        end else if (ce) begin
            sync_prev_r <= sync_sel;
            limit_prev_r <= limit_any;
            sync_tick <= sync_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output on/off

    always @* begin
        out_on_nxt = out_on_r;
        if (sw_on | cmd_fall[`ECP_CMD_ON]) begin
            out_on_nxt = 1'b1;
        end
        // off wins a tie: a lost off is worse than a lost on
        if (sw_off | cmd_fall[`ECP_CMD_OFF] | ~unit_running) begin
            out_on_nxt = 1'b0;
        end
    end

    assign output_enable = out_on_r;

    always @(posedge clock) begin
        if (srst) begin
            out_on_r <= 1'b0;
        end else if (ce) begin
            out_on_r <= out_on_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequence control

    always @* begin
        seq_state_nxt = seq_state_r;
        step_nxt = step_r;
        case (seq_state_r)
            SEQ_IDLE: begin
                if (cmd_fall[`ECP_CMD_START]) begin
                    seq_state_nxt = SEQ_RUN;
                    step_nxt = {`ECP_SEQ_W{1'b0}};
                end
            end
            SEQ_RUN: begin
                if (cmd_fall[`ECP_CMD_STOP]) begin
                    seq_state_nxt = SEQ_IDLE;
                end else if (cmd_fall[`ECP_CMD_HOLD]) begin
                    seq_state_nxt = SEQ_HOLD;
                end else if (cmd_fall[`ECP_CMD_BR0]) begin
                    step_nxt = br0_target;
                end else if (cmd_fall[`ECP_CMD_BR1]) begin
                    step_nxt = br1_target;
                end else if (sync_rise) begin
                    // steps advance on the selected sync source
                    if (step_r == last_step) begin
                        seq_state_nxt = SEQ_IDLE;
                    end else begin
                        step_nxt = step_r + 8'h01;
                    end
                end
            end
            SEQ_HOLD: begin
                if (cmd_fall[`ECP_CMD_STOP]) begin
                    seq_state_nxt = SEQ_IDLE;
                end else if (cmd_fall[`ECP_CMD_START]) begin
                    seq_state_nxt = SEQ_RUN;
                end
            end
            default: begin
                seq_state_nxt = SEQ_IDLE;
            end
        endcase
    end

    always @(posedge clock) begin
        if (srst) begin
            seq_state_r <= SEQ_IDLE;
            step_r <= {`ECP_SEQ_W{1'b0}};
        end else if (ce) begin
            seq_state_r <= seq_state_nxt;
            step_r <= step_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, set wins over write-one-to-clear

    always @* begin
        int_sts_nxt = int_sts_r;
        if (wr_en & hit(paddr, `ECP_OFS_INT_STS)) begin
            int_sts_nxt = int_sts_nxt & ~pwdata[`ECP_INT_W-1:0];
        end
        int_sts_nxt[`ECP_CMD_N-1:0] = int_sts_nxt[`ECP_CMD_N-1:0] | cmd_fall;
        int_sts_nxt[`ECP_INT_LIMIT] = int_sts_nxt[`ECP_INT_LIMIT] | (ce & limit_any & ~limit_prev_r);
    end

    assign irq = |(int_sts_r & int_mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    always @(posedge clock) begin
        if (srst) begin
            ctrl_r <= `ECP_CTRL_RST;
            int_sts_r <= {`ECP_INT_W{1'b0}};
            int_mask_r <= `ECP_INT_MASK_RST;
            seq_cfg_r <= `ECP_SEQ_CFG_RST;
        end else if (ce) begin
            int_sts_r <= int_sts_nxt;
            if (wr_en & hit(paddr, `ECP_OFS_CTRL)) begin
                ctrl_r <= pwdata[`ECP_CTRL_W-1:0];
            end
            if (wr_en & hit(paddr, `ECP_OFS_INT_MASK)) begin
                int_mask_r <= pwdata[`ECP_INT_W-1:0];
            end
            if (wr_en & hit(paddr, `ECP_OFS_SEQ_CFG)) begin
                seq_cfg_r <= pwdata[23:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads

    always @* begin
        rd_val = 32'h00000000;
        rd_ok = 1'b1;
        if (hit(paddr, `ECP_OFS_CTRL)) begin
            rd_val[`ECP_CTRL_W-1:0] = ctrl_r;
        end else if (hit(paddr, `ECP_OFS_OUTCMD)) begin
            rd_val[0] = out_on_r;
        end else if (hit(paddr, `ECP_OFS_STATUS)) begin
            rd_val[0] = unit_running;
            rd_val[1] = out_on_r;
            rd_val[2] = limit_any;
            rd_val[3] = ctrl_r[`ECP_CTRL_FW_BUSY];
            rd_val[6:4] = seq_state_r;
            rd_val[7] = sync_sel;
            rd_val[8] = power_state;
            rd_val[9] = output_state;
            rd_val[10] = limiter_active;
            rd_val[11] = software_busy;
            rd_val[12] = seq_sync0;
            rd_val[13] = seq_sync1;
            rd_val[22:16] = cmd_level;
            rd_val[23] = spare_in;
        end else if (hit(paddr, `ECP_OFS_INT_STS)) begin
            rd_val[`ECP_INT_W-1:0] = int_sts_r;
        end else if (hit(paddr, `ECP_OFS_INT_MASK)) begin
            rd_val[`ECP_INT_W-1:0] = int_mask_r;
        end else if (hit(paddr, `ECP_OFS_SEQ_CFG)) begin
            rd_val[23:0] = seq_cfg_r;
        end else if (hit(paddr, `ECP_OFS_SEQ_STEP)) begin
            rd_val[`ECP_SEQ_W-1:0] = step_r;
        end else begin
            rd_ok = 1'b0;
        end
    end

    // captured at setup so read data and error leave flip-flops
    always @(posedge clock) begin
        if (srst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (ce & setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_val;
            pslverr <= ~rd_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // connector status outputs

    always @(posedge clock) begin
        if (srst) begin
            power_state <= 1'b0;
            output_state <= 1'b0;
            limiter_active <= 1'b0;
            software_busy <= 1'b0;
            seq_sync0 <= 1'b0;
            seq_sync1 <= 1'b0;
        end else if (ce) begin
            // all lines forced low while the port is disabled
            power_state <= ext_en & unit_running;
            output_state <= ext_en & out_on_nxt;
            limiter_active <= ext_en & limit_any;
            software_busy <= ext_en & ctrl_r[`ECP_CTRL_FW_BUSY];
            // sync bits only reach the pins while a sequence is active
            seq_sync0 <= ext_en & ~seq_state_nxt[0] & ctrl_r[`ECP_CTRL_SYNC0];
            seq_sync1 <= ext_en & ~seq_state_nxt[0] & ctrl_r[`ECP_CTRL_SYNC1];
        end
    end

    // undefined connector outputs held at a known low level
    assign spare_out0 = 1'b0;
    assign spare_out1 = 1'b0;

endmodule // external_control_io_port

`default_nettype wire

// file: test/ecp_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ecp_checker (
    // clock, reset, apb
    input wire clock, srst, ce, psel, penable, pwrite, irq,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    // connector and unit state
    input wire output_off_n, output_on_n, seq_branch0_n, seq_branch1_n,
    input wire power_state, output_state, limiter_active, software_busy,
    input wire seq_sync0, seq_sync1, unit_running, line_sync, sync_tick,
    input wire limit_peak_pos, limit_peak_neg, limit_avg_current, limit_power
);
    logic en_r, sel_r;
    logic [7:0] mask_r;
    wire acc = psel && penable && pwrite && ce;
    wire wr_ctrl = acc && paddr == 8'h00;
    wire wr_on = acc && paddr == 8'h04 && pwdata[0];
    wire lim = limit_peak_pos || limit_peak_neg || limit_avg_current || limit_power;
    ////////////////////////////////////////////////////////////////
    // shadow of enable, sync select and mask, taken at the write edge
    always @(posedge clock) begin
        if (srst) begin
            en_r <= 1'b0;
            sel_r <= 1'b1;
            mask_r <= 8'h00;
        end else if (wr_ctrl) begin
            en_r <= pwdata[0];
            sel_r <= pwdata[1];
        end else if (acc && paddr == 8'h10) begin
            mask_r <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    a_gate_all_off: assert property (!en_r && !$past(en_r) |->
        !(power_state || output_state || limiter_active || software_busy || seq_sync0 || seq_sync1))
        else $error("status active while disabled");
    a_power_follow: assert property (!$past(srst) |-> power_state == $past(en_r && unit_running))
        else $error("power line wrong");
    a_limit_follow: assert property (!$past(srst) |-> limiter_active == $past(en_r && lim))
        else $error("limiter line wrong");
    a_on_at_fall: assert property (en_r && unit_running && output_off_n && $fell(output_on_n) |=>
        output_state)
        else $error("output not on");
    a_off_at_fall: assert property (en_r && $fell(output_off_n) |=> !output_state)
        else $error("output not off");
    a_no_stray_on: assert property (!output_state && !wr_on && !wr_ctrl && !$past(wr_ctrl) &&
        !$fell(output_on_n) |=> !output_state)
        else $error("output on without command");
    a_branch0_irq: assert property (en_r && mask_r[5] && $fell(seq_branch0_n) |-> ##1 irq)
        else $error("branch 0 lost");
    a_branch1_irq: assert property (en_r && mask_r[6] && $fell(seq_branch1_n) |=> irq)
        else $error("branch 1 lost");
    a_line_tick: assert property (sel_r && $rose(line_sync) |-> ##[1:3] sync_tick)
        else $error("no line tick");
    a_line_only: assert property ((sel_r && !line_sync) [*4] |-> !sync_tick)
        else $error("tick while line idle");
    c_output_on: cover property (en_r && $fell(output_on_n));
    c_branch_irq: cover property (mask_r[6] && $fell(seq_branch1_n));
    c_line_tick: cover property (sel_r && sync_tick);
endmodule // ecp_checker
bind external_control_io_port ecp_checker i_ecp_checker (.*);
`default_nettype wire

// file: test/ext_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module ext_ctl (
    // clock
    input wire logic clock,
    // command pins, idle high: off, on, start, stop, hold, branch 0, branch 1
    output logic [6:0] cmd_n
);
    initial cmd_n = 7'h7F;
    ////////////////////////////////////////////////////////////////
    // short hold mimics a fast controller, a long one a slow switch
    task automatic hit(input int idx, input int hold);
        @(posedge clock);
        cmd_n[idx] <= 1'b0;
        repeat (hold) @(posedge clock);
        cmd_n[idx] <= 1'b1;
    endtask
endmodule // ext_ctl
`default_nettype wire

// file: test/external_control_io_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ext_ctrl_defines.vh"
module external_control_io_port_tb_top;
    logic clock = 1'b0, srst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic spare_in = 1'b0, unit_running = 1'b0, line_sync = 1'b0, external_sync_input = 1'b0;
    logic [3:0] lim = 4'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, power_state, output_state, limiter_active, software_busy;
    logic seq_sync0, seq_sync1, sync_tick, err, out_en, spare_out0, spare_out1;
    logic output_off_n, output_on_n, seq_start_n, seq_stop_n, seq_hold_n, seq_branch0_n, seq_branch1_n;
    int miscompares = 0, checks_done = 0, cycles = 0, ticks = 0, t0;
    external_control_io_port i_external_control_io_port (
        .clock, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .output_off_n, .output_on_n, .seq_start_n, .seq_stop_n, .seq_hold_n, .seq_branch0_n, .seq_branch1_n,
        .spare_in, .power_state, .output_state, .limiter_active, .software_busy, .seq_sync0, .seq_sync1,
        .spare_out0, .spare_out1, .unit_running, .limit_peak_pos(lim[0]), .limit_peak_neg(lim[1]),
        .limit_avg_current(lim[2]), .limit_power(lim[3]), .line_sync, .external_sync_input, .sync_tick,
        .output_enable(out_en)
    );
    ext_ctl i_ext_ctl (
        .clock,
        .cmd_n({seq_branch1_n, seq_branch0_n, seq_hold_n, seq_stop_n, seq_start_n, output_on_n, output_off_n})
    );
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (sync_tick === 1'b1) ticks <= ticks + 1;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // no local limit: only the bench timeout ends a stalled access
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic sx();
        repeat (2) @(negedge clock);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rdchk(`ECP_OFS_CTRL, 32'h2);
        rdchk(`ECP_OFS_INT_MASK, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        chk({spare_out1, spare_out0}, 2'h0);
        $display("reset test done");
        unit_running <= 1'b1;
        lim <= 4'h1;
        i_ext_ctl.hit(`ECP_CMD_ON, 2);
        sx();
        chk({power_state, output_state, limiter_active}, 3'h0);
        apb(1'b0, `ECP_OFS_INT_STS, 32'h0);
        chk(rd & 32'h7F, 32'h0);
        rdchk(`ECP_OFS_OUTCMD, 32'h0);
        $display("disabled test done");
        lim <= 4'h0;
        apb(1'b1, `ECP_OFS_CTRL, 32'h1);
        apb(1'b1, `ECP_OFS_INT_MASK, 32'hFF);
        apb(1'b1, `ECP_OFS_INT_STS, 32'hFF);
        sx();
        chk(power_state, 1'b1);
        @(posedge clock);
        unit_running <= 1'b0;
        sx();
        chk(power_state, 1'b0);
        @(posedge clock);
        unit_running <= 1'b1;
        $display("power test done");
        // clear while the pin is still low, so a release must not set it again
        fork
            i_ext_ctl.hit(`ECP_CMD_ON, 12);
            begin
                repeat (2) @(posedge clock);
                rdchk(`ECP_OFS_INT_STS, 32'h2);
                chk(irq, 1'b1);
                apb(1'b1, `ECP_OFS_INT_STS, 32'h2);
            end
        join
        sx();
        chk({irq, output_state}, 2'h1);
        rdchk(`ECP_OFS_INT_STS, 32'h0);
        rdchk(`ECP_OFS_OUTCMD, 32'h1);
        chk(out_en, 1'b1);
        i_ext_ctl.hit(`ECP_CMD_OFF, 1);
        sx();
        chk(output_state, 1'b0);
        chk(out_en, 1'b0);
        apb(1'b1, `ECP_OFS_INT_STS, 32'hFF);
        $display("output test done");
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            lim <= 4'h1 << i;
            sx();
            chk(limiter_active, 1'b1);
            @(posedge clock);
            lim <= 4'h0;
            sx();
            chk(limiter_active, 1'b0);
        end
        rdchk(`ECP_OFS_INT_STS, 32'h80);
        apb(1'b1, `ECP_OFS_INT_STS, 32'hFF);
        $display("limiter test done");
        // distinct branch targets so each branch shows in the step register
        apb(1'b1, `ECP_OFS_SEQ_CFG, 32'h100503);
        apb(1'b1, `ECP_OFS_CTRL, 32'h1D);
        i_ext_ctl.hit(`ECP_CMD_START, 1);
        sx();
        chk({software_busy, seq_sync1, seq_sync0}, 3'h7);
        i_ext_ctl.hit(`ECP_CMD_BR0, 1);
        rdchk(`ECP_OFS_SEQ_STEP, 32'h3);
        i_ext_ctl.hit(`ECP_CMD_BR1, 3);
        rdchk(`ECP_OFS_SEQ_STEP, 32'h5);
        rdchk(`ECP_OFS_INT_STS, 32'h64);
        i_ext_ctl.hit(`ECP_CMD_STOP, 1);
        sx();
        chk({seq_sync1, seq_sync0}, 2'h0);
        i_ext_ctl.hit(`ECP_CMD_HOLD, 1);
        rdchk(`ECP_OFS_INT_STS, 32'h7C);
        apb(1'b1, `ECP_OFS_CTRL, 32'h1);
        sx();
        chk(software_busy, 1'b0);
        $display("sequence test done");
        apb(1'b1, `ECP_OFS_CTRL, 32'h3);
        t0 = ticks;
        repeat (4) begin
            @(posedge clock);
            external_sync_input <= ~external_sync_input;
            repeat (3) @(posedge clock);
        end
        chk(ticks - t0, 32'h0);
        line_sync <= 1'b1;
        repeat (5) @(posedge clock);
        line_sync <= 1'b0;
        sx();
        chk(ticks - t0, 32'h1);
        $display("sync test done");
        print_verdict();
    end
endmodule // external_control_io_port_tb_top
`default_nettype wire
